// ---- design/tdp_top.sv ----
`default_nettype none
module tdp_top #(
    parameter int BSR_W = tdp_pkg::BSR_LEN   // boundary chain length
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    // mode and shared pins
    input  wire logic             test_mode_select_i,
    input  wire logic             tck_i,
    input  wire logic             tms_breakpoint_request_i,
    input  wire logic             serial_in_i,
    input  wire logic             trst_n_debug_serial_clock_i,
    input  wire logic             force_high_impedance_n_i,
    // serial output pin
    output logic                  serial_out_o,
    output logic                  serial_out_oe_o,
    // status and debug data pins
    output logic [3:0]            processor_status_code_o,
    output logic                  processor_status_code_oe_o,
    output logic [3:0]            debug_data_bus_o,
    output logic                  debug_data_bus_oe_o,
    // core side
    input  wire logic [3:0]       core_status_i,
    input  wire logic             core_status_vld_i,
    input  wire logic [3:0]       core_data_i,
    output logic                  breakpoint_request_o,
    // debug serial link to core
    output logic                  dbg_rx_bit_o,
    output logic                  dbg_rx_vld_o,
    input  wire logic             dbg_tx_bit_i,
    // boundary chain
    input  wire logic [BSR_W-1:0] bsr_pins_i,
    output logic [BSR_W-1:0]      bsr_update_o,
    output logic                  tap_reset_o
);
    import tdp_pkg::*;

    // synchronised pins and edges
    logic [PIN_W-1:0] pins_s;       // filtered pin levels
    logic             tck_q_ff;     // previous tck level
    logic             dclk_q_ff;    // previous debug clock level
    logic             tck_rise;
    logic             tck_fall;
    logic             dclk_rise;
    logic             dclk_fall;
    logic             dbg_mode;     // debug pin mode
    logic             tap_rst_n;    // test logic reset
    logic             tap_rst_raw_n; // test reset before release stages
    logic [2:0]       trst_rel_ff;  // release stages of test reset
    logic             hiz_force;    // float request
    // test controller
    tdp_tap_e         st_ff;
    tdp_tap_e         nxt_st;
    logic [IR_W-1:0]  ir_sh_ff;     // instruction shifter
    logic [IR_W-1:0]  ir_ff;        // current instruction
    logic [BSR_W-1:0] bsr_sh_ff;    // boundary shifter
    logic [BSR_W-1:0] bsr_upd_ff;   // boundary update latch
    logic             byp_ff;       // bypass bit
    logic             bsr_sel;      // boundary chain chosen
    logic             tdo_ff;       // test data out value
    logic             tdo_en_ff;    // shifting out
    // debug side
    logic             breakpoint_request_ff;
    logic             rx_bit_ff;
    logic             rx_vld_ff;
    logic             dso_ff;
    logic [3:0]       debug_data_bus_ff;

    tdp_sts_if sts_if ();

    // pin filter, three stages each
    tdp_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST)
    ) tdp_sync_inst (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .raw_i     ({trst_n_debug_serial_clock_i, serial_in_i,
                     tms_breakpoint_request_i, tck_i}),
        .flt_o     (pins_s)
    );

    // mode and asynchronous controls
    assign dbg_mode      = test_mode_select_i;
    assign tap_rst_raw_n = rst_n_i &
                           (dbg_mode | trst_n_debug_serial_clock_i);
    assign hiz_force     = ~dbg_mode & ~force_high_impedance_n_i;

    // test reset: immediate entry, release three clocks later
    // keeps the release of test registers away from clock edges
    always_ff @(posedge clk_sys_i or negedge tap_rst_raw_n) begin
        if (!tap_rst_raw_n) begin
            trst_rel_ff <= '0;
        end else begin
            trst_rel_ff <= {trst_rel_ff[1:0], 1'b1};
        end
    end

    assign tap_rst_n = trst_rel_ff[2];

    // previous clock levels for edge finding
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tck_q_ff  <= 1'b0;
            dclk_q_ff <= 1'b1;
        end else begin
            tck_q_ff  <= pins_s[PIN_TCK];
            dclk_q_ff <= pins_s[PIN_CLK];
        end
    end

    // edges count only in the matching mode
    assign tck_rise  = ~dbg_mode & pins_s[PIN_TCK] & ~tck_q_ff;
    assign tck_fall  = ~dbg_mode & ~pins_s[PIN_TCK] & tck_q_ff;
    assign dclk_rise = dbg_mode & pins_s[PIN_CLK] & ~dclk_q_ff;
    assign dclk_fall = dbg_mode & ~pins_s[PIN_CLK] & dclk_q_ff;

    // controller next state from mode select sample
    function automatic tdp_tap_e tdp_next(input tdp_tap_e s,
                                          input logic     m);
        case (s)
            TS_TLR:  tdp_next = m ? TS_TLR  : TS_RTI;
            TS_RTI:  tdp_next = m ? TS_SDR  : TS_RTI;
            TS_SDR:  tdp_next = m ? TS_SIR  : TS_CDR;
            TS_CDR:  tdp_next = m ? TS_E1DR : TS_SHDR;
            TS_SHDR: tdp_next = m ? TS_E1DR : TS_SHDR;
            TS_E1DR: tdp_next = m ? TS_UDR  : TS_PDR;
            TS_PDR:  tdp_next = m ? TS_E2DR : TS_PDR;
            TS_E2DR: tdp_next = m ? TS_UDR  : TS_SHDR;
            TS_UDR:  tdp_next = m ? TS_SDR  : TS_RTI;
            TS_SIR:  tdp_next = m ? TS_TLR  : TS_CIR;
            TS_CIR:  tdp_next = m ? TS_E1IR : TS_SHIR;
            TS_SHIR: tdp_next = m ? TS_E1IR : TS_SHIR;
            TS_E1IR: tdp_next = m ? TS_UIR  : TS_PIR;
            TS_PIR:  tdp_next = m ? TS_E2IR : TS_PIR;
            TS_E2IR: tdp_next = m ? TS_UIR  : TS_SHIR;
            TS_UIR:  tdp_next = m ? TS_SDR  : TS_RTI;
            default: tdp_next = TS_TLR;
        endcase
    endfunction : tdp_next

    // next state, held unless tck rises
    always_comb begin
        nxt_st = st_ff;
        if (tck_rise) begin
            nxt_st = tdp_next(st_ff, pins_s[PIN_TMS]);
        end
    end

    // controller state, kept while tck stands
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            st_ff <= TS_TLR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // extest decode, shared by chain select and update
    function automatic logic tdp_is_extest(input logic [IR_W-1:0] i);
        tdp_is_extest = (i == IR_EXTEST);
    endfunction : tdp_is_extest

    // boundary chain chosen by instruction
    assign bsr_sel = tdp_is_extest(ir_ff) || (ir_ff == IR_SAMPLE);

    // instruction shifter
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_ff <= IR_CAP_VAL;
        end else if (tck_rise && st_ff == TS_CIR) begin
            ir_sh_ff <= IR_CAP_VAL;
        end else if (tck_rise && st_ff == TS_SHIR) begin
            ir_sh_ff <= {pins_s[PIN_SIN], ir_sh_ff[IR_W-1:1]};
        end
    end

    // current instruction
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_ff <= IR_BYPASS;
        end else if (tck_rise && st_ff == TS_TLR) begin
            ir_ff <= IR_BYPASS;
        end else if (tck_rise && st_ff == TS_UIR) begin
            ir_ff <= ir_sh_ff;
        end
    end

    // boundary shifter
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr_sh_ff <= '0;
        end else if (tck_rise && bsr_sel && st_ff == TS_CDR) begin
            bsr_sh_ff <= bsr_pins_i;
        end else if (tck_rise && bsr_sel && st_ff == TS_SHDR) begin
            bsr_sh_ff <= {pins_s[PIN_SIN], bsr_sh_ff[BSR_W-1:1]};
        end
    end

    // boundary update latch, only under extest
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr_upd_ff <= '0;
        end else if (tck_rise && tdp_is_extest(ir_ff) && st_ff == TS_UDR) begin
            bsr_upd_ff <= bsr_sh_ff;
        end
    end

    // bypass bit
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_ff <= 1'b0;
        end else if (tck_rise && !bsr_sel && st_ff == TS_CDR) begin
            byp_ff <= 1'b0;
        end else if (tck_rise && !bsr_sel && st_ff == TS_SHDR) begin
            byp_ff <= pins_s[PIN_SIN];
        end
    end

    // test data out on falling tck
    always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_ff    <= 1'b0;
            tdo_en_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_en_ff <= (st_ff == TS_SHIR) || (st_ff == TS_SHDR);
            if (st_ff == TS_SHIR) begin
                tdo_ff <= ir_sh_ff[0];
            end else if (bsr_sel) begin
                tdo_ff <= bsr_sh_ff[0];
            end else begin
                tdo_ff <= byp_ff;
            end
        end
    end

    // breakpoint level, active low pin
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            breakpoint_request_ff <= 1'b0;
        end else begin
            breakpoint_request_ff <= dbg_mode & ~pins_s[PIN_TMS];
        end
    end

    // debug serial receive on rising debug clock
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_bit_ff <= 1'b0;
            rx_vld_ff <= 1'b0;
        end else begin
            rx_vld_ff <= dclk_rise;
            if (dclk_rise) begin
                rx_bit_ff <= pins_s[PIN_SIN];
            end
        end
    end

    // debug serial send on falling debug clock
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dso_ff <= 1'b0;
        end else if (dclk_fall) begin
            dso_ff <= dbg_tx_bit_i;
        end
    end

    // debug data capture
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            debug_data_bus_ff <= '0;
        end else begin
            debug_data_bus_ff <= core_data_i;
        end
    end

    // status cleaner
    assign sts_if.code = core_status_i;
    assign sts_if.vld  = core_status_vld_i;

    tdp_status tdp_status_inst (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .sts       (sts_if)
    );

    // serial output mux; force-float leaves test data out alone
    assign serial_out_o    = dbg_mode ? dso_ff : tdo_ff;
    assign serial_out_oe_o = dbg_mode |
                             (tdo_en_ff & trst_n_debug_serial_clock_i);

    // status pins only in debug mode
    assign processor_status_code_o    = sts_if.processor_status_code;
    assign processor_status_code_oe_o = dbg_mode;

    // debug data pins float on force-float
    assign debug_data_bus_o    = debug_data_bus_ff;
    assign debug_data_bus_oe_o = ~hiz_force;

    // core side
    assign breakpoint_request_o = breakpoint_request_ff;
    assign dbg_rx_bit_o         = rx_bit_ff;
    assign dbg_rx_vld_o         = rx_vld_ff;
    assign bsr_update_o         = bsr_upd_ff;
    assign tap_reset_o          = (st_ff == TS_TLR);
endmodule : tdp_top
`default_nettype wire

// ---- common/tdp_pkg.sv ----
`default_nettype none
package tdp_pkg;
    // instruction register
    localparam int         IR_W       = 4;
    localparam logic [3:0] IR_BYPASS  = 4'hf;   // loaded by test reset
    localparam logic [3:0] IR_EXTEST  = 4'h0;
    localparam logic [3:0] IR_SAMPLE  = 4'h2;
    localparam logic [3:0] IR_CAP_VAL = 4'h1;   // captured into ir shifter
    // boundary chain length default
    localparam int         BSR_LEN    = 8;
    // input synchroniser bit positions
    localparam int         PIN_W      = 4;
    localparam int         PIN_TCK    = 0;
    localparam int         PIN_TMS    = 1;      // also breakpoint
    localparam int         PIN_SIN    = 2;      // tdi or debug in
    localparam int         PIN_CLK    = 3;      // reset or debug clock
    localparam logic [3:0] PIN_RST    = 4'he;   // idle levels of pins
    // processor status codes
    localparam logic [3:0] PS_CONT    = 4'h0;
    localparam logic [3:0] PS_INSN    = 4'h1;
    localparam logic [3:0] PS_USER    = 4'h3;
    localparam logic [3:0] PS_PULSE   = 4'h4;
    localparam logic [3:0] PS_BRANCH  = 4'h5;
    localparam logic [3:0] PS_RTE     = 4'h7;
    localparam logic [3:0] PS_EXC     = 4'hc;
    localparam logic [3:0] PS_EMU     = 4'hd;
    localparam logic [3:0] PS_STOP    = 4'he;
    localparam logic [3:0] PS_HALT    = 4'hf;
    localparam int         MIN_HOLD   = 2;      // cycles for long codes

    // test controller states, one-hot
    typedef enum logic [15:0] {
        TS_TLR  = 16'h0001, TS_RTI  = 16'h0002,
        TS_SDR  = 16'h0004, TS_CDR  = 16'h0008,
        TS_SHDR = 16'h0010, TS_E1DR = 16'h0020,
        TS_PDR  = 16'h0040, TS_E2DR = 16'h0080,
        TS_UDR  = 16'h0100, TS_SIR  = 16'h0200,
        TS_CIR  = 16'h0400, TS_SHIR = 16'h0800,
        TS_E1IR = 16'h1000, TS_PIR  = 16'h2000,
        TS_E2IR = 16'h4000, TS_UIR  = 16'h8000
    } tdp_tap_e;

    // reserved status code check
    function automatic logic tdp_reserved(input logic [3:0] c);
        tdp_reserved = (c == 4'h2) || (c == 4'h6) || (c[3:2] == 2'b10);
    endfunction : tdp_reserved

    // codes that stand for several cycles
    function automatic logic tdp_long(input logic [3:0] c);
        tdp_long = (c[3:2] == 2'b11);
    endfunction : tdp_long
endpackage : tdp_pkg
`default_nettype wire

// ---- common/tdp_sts_if.sv ----
`default_nettype none
interface tdp_sts_if;
    logic [3:0] code;   // core status request
    logic       vld;    // request present
    logic [3:0] processor_status_code;    // cleaned, registered status
    modport src  (output code, output vld, input processor_status_code);
    modport sink (input code, input vld, output processor_status_code);
endinterface : tdp_sts_if
`default_nettype wire

// ---- design/tdp_sync.sv ----
`default_nettype none
module tdp_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    // raw and filtered levels
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] flt_o
);
    logic [W-1:0] s1_ff;    // first stage, read only by s2
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    // three-stage chain
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= raw_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // bit changes only when stages two and three agree
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_ff <= RST_VAL;
        end else begin
            out_ff <= ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
        end
    end

    assign flt_o = out_ff;
endmodule : tdp_sync
`default_nettype wire

// ---- design/tdp_status.sv ----
`default_nettype none
module tdp_status
    import tdp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // status request and result
    tdp_sts_if.sink   sts
);
    logic [3:0] pst_ff;     // registered status code
    logic [1:0] hold_ff;    // cycles left on a long code

    // pick the code to show each cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pst_ff  <= PS_CONT;
            hold_ff <= '0;
        end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - 2'd1;
        end else if (sts.vld && !tdp_reserved(sts.code)) begin
            pst_ff  <= sts.code;
            hold_ff <= tdp_long(sts.code) ?
                       2'(MIN_HOLD - 1) : 2'd0;
        end else begin
            pst_ff  <= PS_CONT;
        end
    end

    assign sts.processor_status_code = pst_ff;
endmodule : tdp_status
`default_nettype wire

// ---- tb/tdp_asserts.sv ----
`default_nettype none
module tdp_asserts (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    // pins
    input wire logic       test_mode_select_i,
    input wire logic       tms_breakpoint_request_i,
    input wire logic       trst_n_debug_serial_clock_i,
    input wire logic       force_high_impedance_n_i,
    input wire logic       serial_out_oe_o,
    input wire logic [3:0] processor_status_code_o,
    input wire logic       processor_status_code_oe_o,
    input wire logic [3:0] debug_data_bus_o,
    input wire logic       debug_data_bus_oe_o,
    // core side
    input wire logic [3:0] core_status_i,
    input wire logic       core_status_vld_i,
    input wire logic [3:0] core_data_i,
    input wire logic       breakpoint_request_o,
    input wire logic       tap_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic [3:0] ps = processor_status_code_o;  // shorthand
    wire logic       md = test_mode_select_i;       // debug pins chosen
    wire logic       tr = trst_n_debug_serial_clock_i;
    wire logic       lg = (ps[3:2] == 2'b11);        // long code shown
    wire logic [3:0] cs = core_status_i;
    a_status_oe_mode: assert property (
        processor_status_code_oe_o == md) else $error("status enable off");
    a_no_reserved: assert property (
        !(ps == 4'h2 || ps == 4'h6 || ps[3:2] == 2'b10))
        else $error("reserved status code");
    a_long_hold: assert property (
        (lg && ps != $past(ps)) |=> $stable(ps))
        else $error("long status code too short");
    a_idle_continue: assert property (
        (!core_status_vld_i && !lg) |=> ps == 4'h0)
        else $error("idle status not continue");
    a_code_passes: assert property (
        (core_status_vld_i && !lg && cs != 4'h2 && cs != 4'h6
         && cs[3:2] != 2'b10) |=> ps == $past(cs))
        else $error("status code not shown");
    a_breakpoint_request_level: assert property (
        (md && !tms_breakpoint_request_i) [*6] |-> breakpoint_request_o)
        else $error("breakpoint not raised");
    a_breakpoint_request_test_mode: assert property (
        !md |-> !breakpoint_request_o) else $error("breakpoint in test");
    a_tdo_float_trst: assert property (
        (!md && !tr) |-> !serial_out_oe_o) else $error("tdo driven");
    a_dso_driven: assert property (
        md |-> serial_out_oe_o) else $error("debug out floats");
    a_float_input: assert property (
        debug_data_bus_oe_o == (md || force_high_impedance_n_i))
        else $error("float input ignored");
    a_data_delay: assert property (
        $past(rst_n_i) |-> debug_data_bus_o == $past(core_data_i))
        else $error("debug data wrong");
    a_trst_reset: assert property (
        (!md && !tr) |=> tap_reset_o) else $error("trst missed");
endmodule : tdp_asserts
bind tdp_top tdp_asserts tdp_asserts_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .test_mode_select_i(test_mode_select_i),
    .tms_breakpoint_request_i(tms_breakpoint_request_i),
    .trst_n_debug_serial_clock_i(trst_n_debug_serial_clock_i),
    .force_high_impedance_n_i(force_high_impedance_n_i),
    .serial_out_oe_o(serial_out_oe_o),
    .processor_status_code_o(processor_status_code_o),
    .processor_status_code_oe_o(processor_status_code_oe_o),
    .debug_data_bus_o(debug_data_bus_o),
    .debug_data_bus_oe_o(debug_data_bus_oe_o),
    .core_status_i(core_status_i), .core_status_vld_i(core_status_vld_i),
    .core_data_i(core_data_i), .breakpoint_request_o(breakpoint_request_o),
    .tap_reset_o(tap_reset_o));
`default_nettype wire

// ---- tb/tdp_host.sv ----
`default_nettype none
module tdp_host (
    // clock used for pacing
    input  wire logic clk_sys_i,
    // serial output pin
    input  wire logic serial_out_i,
    input  wire logic serial_out_oe_i,
    // shared pins driven by the host
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      trst_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic      tdo_last = 1'b0;  // last driven level
    // released line shows the inverse of its last level
    wire logic tdo_pin = serial_out_oe_i ? serial_out_i : ~tdo_last;
    always @(posedge clk_sys_i) begin
        if (serial_out_oe_i) tdo_last <= serial_out_i;
    end
    // idle levels: clocks still, reset released
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : tick
    // reset released only with select high
    task automatic set_trst(input logic v);
        tms_o = 1'b1;
        trst_n_o = v;
    endtask : set_trst
    task automatic set_tms(input logic v);
        tms_o = v;
    endtask : set_tms
    // one test clock; tdo taken four core clocks after the rise
    task automatic tck_cycle(input logic tms, input logic tdi,
                             output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        tck_o = 1'b0;
        tick(4);
        tck_o = 1'b1;
        tick(4);
        tdo = tdo_pin;
    endtask : tck_cycle
    // one debug bit, 80 ns period, one eighth of the core rate
    task automatic dbg_bit(input logic din, output logic dout);
        tdi_o = din;
        trst_n_o = 1'b0;
        tick(4);
        trst_n_o = 1'b1;
        tick(4);
        dout = tdo_pin;
    endtask : dbg_bit
endmodule : tdp_host
`default_nettype wire

// ---- tb/tdp_top_test.sv ----
`default_nettype none
module tdp_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    logic            mode = 1'b0;
    logic            hiz_n = 1'b1;
    logic [3:0]      sts = 4'h0;
    logic            sts_vld = 1'b0;
    logic [3:0]      cdata = 4'h0;
    logic            tx_bit = 1'b0;
    logic [7:0]      bsr_pins = 8'ha5;
    wire logic       tck, tms, tdi, trst_n, sout, sout_oe, breakpoint_request;
    wire logic       rx_bit, rx_vld, tap_rst, pst_oe, debug_data_bus_oe;
    wire logic [3:0] processor_status_code, debug_data_bus;
    wire logic [7:0] bsr_upd;
    int              n_mismatch = 0;
    int              checks = 0;
    always #5 clk_sys = ~clk_sys;
    tdp_top tdp_top_inst (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .test_mode_select_i(mode),
        .tck_i(tck), .tms_breakpoint_request_i(tms), .serial_in_i(tdi),
        .trst_n_debug_serial_clock_i(trst_n),
        .force_high_impedance_n_i(hiz_n), .serial_out_o(sout),
        .serial_out_oe_o(sout_oe), .processor_status_code_o(processor_status_code),
        .processor_status_code_oe_o(pst_oe), .debug_data_bus_o(debug_data_bus),
        .debug_data_bus_oe_o(debug_data_bus_oe), .core_status_i(sts),
        .core_status_vld_i(sts_vld), .core_data_i(cdata),
        .breakpoint_request_o(breakpoint_request), .dbg_rx_bit_o(rx_bit),
        .dbg_rx_vld_o(rx_vld), .dbg_tx_bit_i(tx_bit),
        .bsr_pins_i(bsr_pins), .bsr_update_o(bsr_upd),
        .tap_reset_o(tap_rst));
    tdp_host tdp_host_inst (
        .clk_sys_i(clk_sys), .serial_out_i(sout), .serial_out_oe_i(sout_oe),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // mode is only changed while reset is held
    task automatic do_reset(input logic m);
        rst_n = 1'b0;
        mode = m;
        tick(20);
        rst_n = 1'b1;
        tick(4);
    endtask : do_reset
    // walk the controller along a select path, first bit first
    task automatic walk(input int n, input logic [7:0] path);
        logic b;
        for (int i = 0; i < n; i++) tdp_host_inst.tck_cycle(path[i], 1'b1, b);
        tick(2);
    endtask : walk
    // shift n bits, lsb first, clock stopped before bit hold
    task automatic shift(input int n, input logic [7:0] din, input int hold,
                         output logic [7:0] dout);
        logic b;
        dout = 8'h00;
        for (int i = 0; i < n; i++) begin
            if (i == hold) tick(50);
            tdp_host_inst.tck_cycle(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask : shift
    task automatic t_trst();
        tdp_host_inst.set_trst(1'b0);
        tick(2);
        cmp(tap_rst, 8'h01, "trst not reset");
        cmp(sout_oe, 8'h00, "tdo driven in trst");
        cmp(pst_oe, 8'h00, "status pins driven");
        hiz_n = 1'b0;
        tick(1);
        cmp(debug_data_bus_oe, 8'h00, "float input ignored");
        hiz_n = 1'b1;
        tdp_host_inst.set_trst(1'b1);
        tick(2);
    endtask : t_trst
    task automatic t_jtag();
        logic [7:0] got;
        walk(5, 8'b00110);
        shift(4, 8'h00, 9, got);
        cmp(got, 8'h01, "instruction capture");
        walk(2, 8'b01);
        cmp(sout_oe, 8'h00, "tdo driven idle");
        walk(3, 8'b001);
        shift(8, 8'h3c, 4, got);
        cmp(got, 8'ha5, "boundary capture");
        walk(2, 8'b01);
        cmp(bsr_upd, 8'h3c, "boundary update");
        walk(5, 8'h1f);
        cmp(tap_rst, 8'h01, "five ones no reset");
        walk(4, 8'b0010);
        shift(2, 8'h03, 9, got);
        cmp(got, 8'h02, "bypass path");
        walk(5, 8'h1f);
        walk(5, 8'b00110);
        shift(4, 8'h02, 9, got);
        walk(5, 8'b00101);
        shift(8, 8'hff, 9, got);
        cmp(got, 8'ha5, "sample capture");
        walk(2, 8'b01);
        cmp(bsr_upd, 8'h3c, "sample changed update");
        walk(5, 8'h1f);
    endtask : t_jtag
    task automatic t_status();
        logic [3:0] e;
        for (int c = 0; c < 16; c++) begin
            sts = c[3:0];
            sts_vld = 1'b1;
            tick(1);
            e = (c == 2 || c == 6 || c / 4 == 2) ? 4'h0 : c[3:0];
            cmp(processor_status_code, e, "status code");
            sts = 4'h1;
            tick(1);
            e = (c >= 12) ? c[3:0] : 4'h1;
            cmp(processor_status_code, e, "status hold");
            sts_vld = 1'b0;
            tick(3);
            cmp(processor_status_code, 8'h00, "idle status");
        end
    endtask : t_status
    task automatic t_debug();
        logic b;
        logic d;
        cmp(pst_oe, 8'h01, "status pins floating");
        tdp_host_inst.set_tms(1'b0);
        tick(6);
        cmp(breakpoint_request, 8'h01, "breakpoint missed");
        tdp_host_inst.set_tms(1'b1);
        tick(6);
        cmp(breakpoint_request, 8'h00, "breakpoint stuck");
        for (int i = 0; i < 4; i++) begin
            tx_bit = i[0];
            d = ~i[1];
            tdp_host_inst.dbg_bit(d, b);
            tick(1);
            cmp(rx_vld, 8'h01, "debug rx strobe");
            tick(1);
            cmp(rx_vld, 8'h00, "debug rx strobe long");
            cmp(rx_bit, d, "debug rx bit");
            cmp(b, i[0], "debug tx bit");
        end
        cdata = 4'h9;
        tick(2);
        cmp(debug_data_bus, 8'h09, "debug data");
    endtask : t_debug
    initial begin
        do_reset(1'b0);
        t_trst();
        t_jtag();
        do_reset(1'b1);
        t_status();
        t_debug();
        conclude();
    end
    // watchdog well beyond the expected eight hundred or so cycles
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule : tdp_top_test
`default_nettype wire
